// ### rtl/adc_ctl_pkg.sv
// Package of register map, field layout and timing constants for ADC control
package adc_ctl_pkg;
    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 8;
    localparam int          SEL_W           = 4;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADC_CONTROL_ZERO_ADDR = 12'hf70;
    localparam logic [11:0] ADC_CONTROL_ONE_ADDR  = 12'hf74;
    localparam logic [11:0] ADC_RESULT_ADDR       = 12'hf78;
    localparam logic [7:0]  CTL0_RESET      = 8'h00;
    localparam logic [7:0]  CTL1_RESET      = 8'h80;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          GO_BIT          = 7;
    localparam int          REF_LSB_BIT     = 6;
    localparam int          REF_BUF_BIT     = 5;
    localparam int          REPEAT_BIT      = 4;
    localparam int          CHAN_MSB        = 3;
    localparam int          REF_MSB_BIT     = 7;
    localparam int          CHAN_W          = 4;
    localparam int          RESULT_W        = 10;

    // ------------------------------------------------------------
    // Channel and reference encodings
    // ------------------------------------------------------------
    localparam logic [3:0]  TEMP_CHANNEL    = 4'he;
    localparam logic [1:0]  REF_EXTERNAL    = 2'h0;
    localparam logic [1:0]  REF_ONE_VOLT    = 2'h1;
    localparam logic [1:0]  REF_TWO_VOLT    = 2'h2;

    // ------------------------------------------------------------
    // Timing in system clock cycles
    // ------------------------------------------------------------
    localparam int          FIRST_CYCLES    = 5129;
    localparam int          UPDATE_CYCLES   = 256;
    localparam int          TEMP_FACTOR     = 2;
    localparam int          CNT_W           = 14;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_FIRST,
        CONV_REPEAT
    } conv_state_t;
endpackage

// ### rtl/adc_result_store.sv
// Result holding register that captures each finished conversion sample
`timescale 1ns/1ps
module adc_result_store (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // Capture side
    input  wire logic                              capture_i,
    input  wire logic [adc_ctl_pkg::RESULT_W-1:0]  sample_i,
    // Read side
    output logic      [adc_ctl_pkg::RESULT_W-1:0]  result_o
);
    import adc_ctl_pkg::*;

    logic [RESULT_W-1:0] result_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_reg <= '0;
        end else if (capture_i) begin
            result_reg <= sample_i;
        end
    end

    assign result_o = result_reg;
endmodule

// ### rtl/adc_conversion_control.sv
// Converter control registers, conversion sequencer and Wishbone slave
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module adc_conversion_control (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // Wishbone slave
    input  wire logic                              cyc_i,
    input  wire logic                              stb_i,
    input  wire logic                              we_i,
    input  wire logic [adc_ctl_pkg::ADDR_W-1:0]    adr_i,
    input  wire logic [adc_ctl_pkg::SEL_W-1:0]     sel_i,
    input  wire logic [adc_ctl_pkg::DATA_W-1:0]    dat_i,
    output logic      [adc_ctl_pkg::DATA_W-1:0]    dat_o,
    output logic                                   ack_o,
    // Analog core
    input  wire logic [adc_ctl_pkg::RESULT_W-1:0]  sample_i,
    output logic      [adc_ctl_pkg::CHAN_W-1:0]    input_channel_sel_o,
    output logic      [1:0]                        ref_level_o,
    output logic                                   ref_buffer_drive_o,
    output logic                                   converting_o,
    output logic                                   result_valid_o
);
    import adc_ctl_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [REG_W-1:0]    ctl0_reg;
    logic [REG_W-1:0]    ctl1_reg;
    logic                ack_reg;
    logic [DATA_W-1:0]   dat_reg;
    conv_state_t         state_reg;
    logic [CNT_W-1:0]    count_reg;
    logic                done_reg;
    logic [CHAN_W-1:0]   chan_reg;
    logic [1:0]          ref_reg;
    logic                buf_reg;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] sample_meta_reg;
    logic [RESULT_W-1:0] sample_sync_reg;
    logic [RESULT_W-1:0] sample_last_reg;
    logic [RESULT_W-1:0] sample_good_reg;

    logic                bus_req;
    logic                wr_ctl0;
    logic                wr_ctl1;
    logic                go_write;
    logic                temp_sel;
    logic [CNT_W-1:0]    first_len;
    logic [CNT_W-1:0]    update_len;
    logic                count_end;
    logic                finish;

    assign bus_req  = cyc_i && stb_i && !ack_reg;
    assign wr_ctl0  = bus_req && we_i && sel_i[0]
                      && adr_i == ADC_CONTROL_ZERO_ADDR;
    assign wr_ctl1  = bus_req && we_i && sel_i[0]
                      && adr_i == ADC_CONTROL_ONE_ADDR;
    assign go_write = wr_ctl0 && dat_i[GO_BIT];

    // ------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------
    assign temp_sel   = ctl0_reg[CHAN_MSB:0] == TEMP_CHANNEL;
    assign first_len  = temp_sel ? CNT_W'(FIRST_CYCLES * TEMP_FACTOR)
                                 : CNT_W'(FIRST_CYCLES);
    assign update_len = temp_sel ? CNT_W'(UPDATE_CYCLES * TEMP_FACTOR)
                                 : CNT_W'(UPDATE_CYCLES);
    assign count_end  = (state_reg == CONV_FIRST
                         && count_reg == first_len - CNT_W'(1))
                     || (state_reg == CONV_REPEAT
                         && count_reg == update_len - CNT_W'(1));
    // A go write in the last cycle restarts; no result escapes
    assign finish     = count_end && !go_write;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= CONV_IDLE;
            count_reg <= '0;
        end else if (go_write) begin
            state_reg <= CONV_FIRST;
            count_reg <= '0;
        end else if (finish) begin
            count_reg <= '0;
            if (ctl0_reg[REPEAT_BIT]) begin
                state_reg <= CONV_REPEAT;
            end else begin
                state_reg <= CONV_IDLE;
            end
        end else if (state_reg != CONV_IDLE) begin
            count_reg <= count_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= finish;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl0_reg <= CTL0_RESET;
        end else if (wr_ctl0) begin
            ctl0_reg[GO_BIT-1:0] <= dat_i[GO_BIT-1:0];
            // Go only sets; a zero write keeps a running bit
            if (dat_i[GO_BIT]) begin
                ctl0_reg[GO_BIT] <= 1'b1;
            end else if (finish && state_reg == CONV_FIRST) begin
                ctl0_reg[GO_BIT] <= 1'b0;
            end
        end else if (finish && state_reg == CONV_FIRST) begin
            // Continuous mode also clears go after the first result
            ctl0_reg[GO_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl1_reg <= CTL1_RESET;
        end else if (wr_ctl1) begin
            ctl1_reg <= dat_i[REG_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Analog steering outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan_reg <= '0;
            ref_reg  <= REF_TWO_VOLT;
            buf_reg  <= 1'b0;
        end else begin
            chan_reg <= ctl0_reg[CHAN_MSB:0];
            ref_reg  <= {ctl1_reg[REF_MSB_BIT],
                         ctl0_reg[REF_LSB_BIT]};
            buf_reg  <= ctl0_reg[REF_BUF_BIT];
        end
    end

    // ------------------------------------------------------------
    // Sample synchroniser
    // ------------------------------------------------------------
    // Core settles on its own timing; a word is taken only once the
    // second and third stages agree, so skewed bits never get through
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_meta_reg <= '0;
            sample_sync_reg <= '0;
            sample_last_reg <= '0;
            sample_good_reg <= '0;
        end else begin
            sample_meta_reg <= sample_i;
            sample_sync_reg <= sample_meta_reg;
            sample_last_reg <= sample_sync_reg;
            if (sample_sync_reg == sample_last_reg) begin
                sample_good_reg <= sample_last_reg;
            end
        end
    end

    adc_result_store u_store (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .capture_i (finish),
        .sample_i  (sample_good_reg),
        .result_o  (result)
    );

    // ------------------------------------------------------------
    // Bus answer: one wait-free cycle, unmapped reads zero
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= bus_req;
            if (bus_req && !we_i) begin
                unique case (adr_i)
                    ADC_CONTROL_ZERO_ADDR:
                        dat_reg <= {{(DATA_W-REG_W){1'b0}}, ctl0_reg};
                    ADC_CONTROL_ONE_ADDR:
                        dat_reg <= {{(DATA_W-REG_W){1'b0}}, ctl1_reg};
                    ADC_RESULT_ADDR:
                        dat_reg <= {{(DATA_W-RESULT_W){1'b0}}, result};
                    default:
                        dat_reg <= '0;
                endcase
            end
        end
    end

    assign dat_o               = dat_reg;
    assign ack_o               = ack_reg;
    assign input_channel_sel_o = chan_reg;
    assign ref_level_o         = ref_reg;
    assign ref_buffer_drive_o  = buf_reg;
    assign converting_o        = ctl0_reg[GO_BIT];
    assign result_valid_o      = done_reg;
endmodule

// ### verification/adc_core_model.sv
// Behavioural analog core behind the converter control block
`timescale 1ns/1ps
module adc_core_model (
    // Steering from the controller
    input  wire logic [3:0] chan_i,
    input  wire logic [1:0] ref_i,
    input  wire logic       buf_i,
    // Sample and pin state back
    output logic      [9:0] sample_o,
    output logic            clash_o
);
    // Sample mirrors the steering so the bench can predict it
    assign sample_o = {chan_i, ref_i, chan_i};
    // Buffer fighting an external reference on the pin
    assign clash_o = buf_i && (ref_i == 2'h0);
endmodule

// ### verification/adc_ctl_sva.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module adc_ctl_sva
    import adc_ctl_pkg::*;
(
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    // Converter side
    input wire logic [3:0]  input_channel_sel_o,
    input wire logic [1:0]  ref_level_o,
    input wire logic        ref_buffer_drive_o,
    input wire logic        converting_o,
    input wire logic        result_valid_o
);
    // ----------
    // Helpers
    // ----------
    logic        wr0, go, tmp, seen_q;
    logic [13:0] run_q, gap_q;
    assign wr0 = cyc_i && stb_i && !ack_o && we_i && sel_i[0]
        && adr_i == ADC_CONTROL_ZERO_ADDR;
    assign go = wr0 && dat_i[GO_BIT];
    assign tmp = input_channel_sel_o == TEMP_CHANNEL;
    // Counting from the last start makes a restart need no special case
    always_ff @(posedge clk_i) begin
        run_q <= (rst_i || go) ? '0 : run_q + 14'h1;
        gap_q <= (rst_i || result_valid_o) ? '0 : gap_q + 14'h1;
        seen_q <= !rst_i && !go && (seen_q || result_valid_o);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    bus_ack_a: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not a single pulse");
    go_start_a: assert property (go |=> converting_o [*8])
        else $error("start not held");
    zero_go_a: assert property (
        wr0 && !dat_i[GO_BIT] && run_q < 14'd5000
        |=> converting_o == $past(converting_o))
        else $error("zero write changed state");
    run_len_a: assert property ($fell(converting_o) |-> run_q ==
        (tmp ? 14'(FIRST_CYCLES * TEMP_FACTOR) : 14'(FIRST_CYCLES)))
        else $error("wrong conversion length");
    result_out_a: assert property (
        $fell(converting_o) |-> ##[0:1] result_valid_o)
        else $error("no result after conversion");
    update_gap_a: assert property (result_valid_o && seen_q |->
        gap_q == (tmp ? 14'(UPDATE_CYCLES * TEMP_FACTOR - 1)
        : 14'(UPDATE_CYCLES - 1)))
        else $error("wrong update spacing");
    ctl_out_a: assert property (wr0 |-> ##2
        input_channel_sel_o == $past(dat_i[3:0], 2)
        && ref_buffer_drive_o == $past(dat_i[REF_BUF_BIT], 2)
        && ref_level_o[0] == $past(dat_i[REF_LSB_BIT], 2))
        else $error("outputs do not follow control");
    reset_val_a: assert property ($fell(rst_i) |->
        ref_level_o == REF_TWO_VOLT && !ref_buffer_drive_o
        && input_channel_sel_o == 4'h0 && !converting_o)
        else $error("bad reset outputs");
endmodule
bind adc_conversion_control adc_ctl_sva adc_ctl_sva_i (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .input_channel_sel_o(input_channel_sel_o), .ref_level_o(ref_level_o),
    .ref_buffer_drive_o(ref_buffer_drive_o), .converting_o(converting_o),
    .result_valid_o(result_valid_o));

// ### verification/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
    import adc_ctl_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic        ack_o, conv, valid, bufd, clash;
    logic [11:0] adr_i = '0;
    logic [3:0]  sel_i = '0, chan;
    logic [31:0] dat_i = '0, dat_o, rdq[$];
    logic [9:0]  sample;
    logic [1:0]  refl;
    int          lenq[$], errors = 0, n_compared = 0, run = 0, n_val = 0;
    adc_conversion_control adc_conversion_control_i (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .sample_i(sample), .input_channel_sel_o(chan),
        .ref_level_o(refl), .ref_buffer_drive_o(bufd),
        .converting_o(conv), .result_valid_o(valid));
    adc_core_model adc_core_model_i (.chan_i(chan), .ref_i(refl),
        .buf_i(bufd), .sample_o(sample), .clash_o(clash));
    initial forever #5 clk_i = ~clk_i;
    // ----------
    // Tasks
    // ----------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic fail_if(input bit hit);
        if (hit) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [7:0] d, input logic [3:0] s);
        int i;
        i = 0;
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, 24'h0, d};
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 16);
        fail_if(i >= 16);
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        rdq.push_back(exp);
        wb(0, a, 8'h00, 4'hf);
    endtask
    task automatic wait_idle;
        int i;
        i = 0;
        while (conv !== 1'b0 && i < 12000) begin
            @(posedge clk_i);
            i++;
        end
        fail_if(i >= 12000);
    endtask
    // Watcher: nonblocking count so the driver sees a stable value
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && !we_i) cmp(dat_o, rdq.size() ? rdq.pop_front() : 'x);
        if (conv === 1'b1) run++;
        else if (run != 0) begin
            cmp(run, lenq.size() ? lenq.pop_front() : -1);
            run = 0;
        end
        if (valid === 1'b1) n_val <= n_val + 1;
        if (!rst_i && clash !== 1'b0) cmp(clash, 0);
    end
    initial begin
        int d, ch, len;
        void'($urandom(32'h58a1));
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        rd(ADC_CONTROL_ZERO_ADDR, 32'h0);
        rd(ADC_CONTROL_ONE_ADDR, 32'h80);
        rd(12'hf7c, 32'h0);
        for (int r = 0; r < 4; r++) begin
            // Buffer only with an internal level, never on the pin level
            d = {1'b0, r[0], r[0], 1'b0, 4'($urandom_range(0, 13))};
            wb(1, ADC_CONTROL_ONE_ADDR, {r[1], 7'h0}, 4'hf);
            wb(1, ADC_CONTROL_ZERO_ADDR, d[7:0], 4'hf);
            wb(1, ADC_CONTROL_ZERO_ADDR, 8'hff, 4'h0);
            rd(ADC_CONTROL_ZERO_ADDR, d);
            cmp({refl, bufd, chan}, {r[1:0], d[5], d[3:0]});
        end
        wb(1, ADC_CONTROL_ONE_ADDR, 8'h80, 4'hf);
        for (int m = 0; m < 4; m++) begin
            ch = m[1] ? TEMP_CHANNEL : $urandom_range(0, 13);
            d = 8'h80 | (m[0] << 4) | ch;
            len = FIRST_CYCLES * (m[1] ? TEMP_FACTOR : 1);
            lenq.push_back(len);
            wb(1, ADC_CONTROL_ZERO_ADDR, d[7:0], 4'hf);
            rd(ADC_CONTROL_ZERO_ADDR, d);
            wb(1, ADC_CONTROL_ZERO_ADDR, {1'b0, d[6:0]}, 4'hf);
            rd(ADC_CONTROL_ZERO_ADDR, d);
            wait_idle();
            rd(ADC_CONTROL_ZERO_ADDR, d & 8'h7f);
            rd(ADC_RESULT_ADDR, {ch[3:0], REF_TWO_VOLT, ch[3:0]});
            d = n_val;
            repeat (1024) @(posedge clk_i);
            cmp(n_val - d, m[0] ? 1024 / (UPDATE_CYCLES * len / FIRST_CYCLES)
                : 0);
            wb(1, ADC_CONTROL_ZERO_ADDR, ch[7:0], 4'hf);
            repeat (600) @(posedge clk_i);
        end
        // Second start lands 53 cycles after the first one
        lenq.push_back(FIRST_CYCLES + 53);
        wb(1, ADC_CONTROL_ZERO_ADDR, 8'h81, 4'hf);
        repeat (50) @(posedge clk_i);
        wb(1, ADC_CONTROL_ZERO_ADDR, 8'h81, 4'hf);
        wait_idle();
        wrap_up();
    end
endmodule
